// ===== rtl/scope_pkg.sv
// shared constants, types and register map of the scope sample rate reducer
// How it works
// [RULE1] a new adc word is taken on every cycle, whatever rate is stored
// [RULE2] a reduced rate combines each group of n adc words into one entry
// [RULE3] averaging stores the group mean, decimating keeps one word of it
// [RULE4] min/max looks at 2n words and stores their minimum and maximum
// [RULE5] min/max therefore stores entries at half the rate of the others
// [RULE6] scope and digital-line capture step on one shared sample tick
// [RULE7] the default build holds 8k entries per channel
// [RULE8] an alternate build allows a depth selectable up to 16k
// [RULE9] a full bank goes to the host and capture restarts at once; here it re-arms only with CTRL_CONT set, else it goes idle
// [RULE10] triggers come from instruments and two pins; ours can drive the pins
// [RULE11] analog gain is only high or low; finer scale is digital zoom
// [RULE12] two independent 14-bit channels, one word each per cycle
// [RULE13] averages use a full-width sum; n of one passes words unchanged
// [RULE14] a done flag rises when the bank is full and clears on restart
package scope_pkg;
  localparam int ADC_W = 14;
  localparam int REC_W = 2 * ADC_W;
  localparam int DIVL_W = 4;
  localparam int CNT_W = 16;
  localparam int ACC_W = ADC_W + CNT_W;
  localparam int DEPTH_W = 15;
  localparam int DEF_DEPTH = 8192;
  localparam int ALT_DEPTH = 16384;
  localparam int TRIG_INST_W = 3;
  localparam int EXT_TRIG_N = 2;
  localparam int TRIG_SRC_W = TRIG_INST_W + EXT_TRIG_N;
  localparam int IRQ_W = 3;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DIV = 8'h04;
  localparam logic [7:0] REG_DEPTH = 8'h08;
  localparam logic [7:0] REG_TRIG = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam logic [7:0] REG_RD_ADDR = 8'h1c;
  localparam logic [7:0] REG_RD_A = 8'h20;
  localparam logic [7:0] REG_RD_B = 8'h24;
  localparam logic [7:0] REG_RELEASE = 8'h28;
  // field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CONT = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_GAIN = 4;
  localparam int CTRL_MIXED = 5;
  localparam int CTRL_FORCE = 6;
  localparam int CTRL_ZOOM = 7;
  localparam int CTRL_STOP = 9;
  localparam int TRIG_OUT = 5;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TRIG = 1;
  localparam int IRQ_OVR = 2;
  typedef enum logic [1:0] {MODE_AVG = 2'h0, MODE_DEC = 2'h1, MODE_MINMAX = 2'h2} mode_t;
  typedef enum logic [1:0] {ACQ_IDLE = 2'h0, ACQ_ARMED = 2'h1, ACQ_CAPT = 2'h3,
                            ACQ_DONE = 2'h2} acq_t;
  typedef struct packed {logic [7:0] addr; logic [31:0] wdata; logic wr; logic rd;} bus_req_t;
  typedef struct packed {logic valid; logic [REC_W-1:0] word;} rec_t;
  typedef struct packed {mode_t mode; logic [DIVL_W-1:0] div_log; logic [1:0] zoom;} red_cfg_t;
endpackage

// ===== rtl/sample_reducer.sv
// one channel of sample rate reduction: average, decimate or min/max
module sample_reducer (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // configuration and group restart
  input scope_pkg::red_cfg_t cfg,
  input wire logic clear,
  // adc word, one each cycle
  input wire logic [scope_pkg::ADC_W-1:0] sample,
  // recorded entry
  output scope_pkg::rec_t rec
);
  import scope_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic signed [ACC_W-1:0] acc;
    logic signed [ADC_W-1:0] mn;
    logic signed [ADC_W-1:0] mx;
    rec_t out;
  } red_state_t;

  red_state_t q_reg, q_next;
  logic [CNT_W-1:0] glen;
  logic signed [ADC_W-1:0] x, mn_in, mx_in;
  logic signed [ACC_W-1:0] acc_in;
  logic first;

  // digital zoom: shift up and clip instead of wrapping
  function automatic logic [ADC_W-1:0] zoom_sat(input logic [ADC_W-1:0] v, input logic [1:0] z);
    logic signed [ADC_W+2:0] w;
    w = $signed({{3{v[ADC_W-1]}}, v}) <<< z;
    if (&w[ADC_W+2:ADC_W-1] || ~|w[ADC_W+2:ADC_W-1]) return w[ADC_W-1:0];
    return {w[ADC_W+2], {(ADC_W-1){~w[ADC_W+2]}}}; // [RULE11]
  endfunction

  // group state update
  always_comb begin
    q_next = q_reg;
    q_next.out.valid = 1'b0;
    x = $signed(sample); // [RULE1]
    // min/max groups are twice as long, so entries come at half the rate
    glen = (cfg.mode == MODE_MINMAX) ? (CNT_W'(2) << cfg.div_log) // [RULE5]
                                     : (CNT_W'(1) << cfg.div_log);
    first = (q_reg.cnt == '0);
    acc_in = first ? ACC_W'(x) : q_reg.acc + ACC_W'(x); // [RULE13]
    mn_in = (first || x < q_reg.mn) ? x : q_reg.mn;
    mx_in = (first || x > q_reg.mx) ? x : q_reg.mx;
    if (clear) begin
      q_next.cnt = '0;
    end else begin
      q_next.acc = acc_in;
      q_next.mn = mn_in;
      q_next.mx = mx_in;
      q_next.cnt = q_reg.cnt + 1'b1;
      if (q_reg.cnt == glen - 1'b1) begin // [RULE2]
        q_next.cnt = '0;
        q_next.out.valid = 1'b1;
        case (cfg.mode) // [RULE3]
          MODE_AVG: q_next.out.word = REC_W'(zoom_sat(ADC_W'(acc_in >>> cfg.div_log), cfg.zoom));
          MODE_MINMAX: q_next.out.word = {zoom_sat(mx_in, cfg.zoom), zoom_sat(mn_in, cfg.zoom)}; // [RULE4]
          default: q_next.out.word = REC_W'(zoom_sat(sample, cfg.zoom)); // last word kept
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) q_reg <= '0;
    else q_reg <= q_next;
  end

  assign rec = q_reg.out;

  a_n1_passthru: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE13]
    cfg.div_log == '0 && cfg.mode != MODE_MINMAX && cfg.zoom == '0 && !clear
    |=> rec.valid && rec.word[ADC_W-1:0] == $past(sample))
    else $error("n of one did not pass the word through");
  a_minmax_order: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE4]
    rec.valid && $past(cfg.mode) == MODE_MINMAX && $past(cfg.zoom) == '0
    |-> $signed(rec.word[REC_W-1:ADC_W]) >= $signed(rec.word[ADC_W-1:0]))
    else $error("min/max pair out of order");
endmodule // sample_reducer

// ===== rtl/capture_buffer.sv
// two capture banks in flip-flops, one written while the host reads the other
module capture_buffer #(
  parameter int WIDTH = 56,
  parameter int DEPTH = 8192,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic core_clk,
  // write side
  input wire logic we,
  input wire logic wbank,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read side, combinational
  input wire logic rbank,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [2][DEPTH];

  // storage has no reset: contents are only valid once a bank is handed over
  always_ff @(posedge core_clk) begin
    if (we) mem[wbank][waddr] <= wdata;
  end

  assign rdata = mem[rbank][raddr];
endmodule // capture_buffer

// ===== rtl/scope_sample_rate_reducer.sv
// top of the scope acquisition path: reducers, capture banks, triggers, registers
//
// Strobed register access and the address map are this design's own decisions.
module scope_sample_rate_reducer #(
  parameter int BUF_DEPTH = scope_pkg::DEF_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,

  // adc words, one per channel each cycle
  input wire logic [scope_pkg::ADC_W-1:0] adc_a,
  input wire logic [scope_pkg::ADC_W-1:0] adc_b,

  // register port
  input scope_pkg::bus_req_t reg_req,
  output logic [31:0] reg_rdata,

  // trigger network and external trigger pins
  input wire logic [scope_pkg::TRIG_INST_W-1:0] trig_inst,
  output logic trig_own,
  input wire logic [scope_pkg::EXT_TRIG_N-1:0] trig_pin_i,
  output logic [scope_pkg::EXT_TRIG_N-1:0] trig_pin_o,
  output logic [scope_pkg::EXT_TRIG_N-1:0] trig_pin_oe_n,

  // front end gain and mixed signal tick
  output logic gain_hi,
  output logic la_sample_tick,

  // buffer hand-off and interrupt
  output logic host_ready,
  output logic host_bank,
  output logic irq
);
  import scope_pkg::*;

  localparam int AW = $clog2(BUF_DEPTH);
  localparam logic [DEPTH_W-1:0] DMAX = DEPTH_W'(BUF_DEPTH);

  typedef struct packed {
    acq_t st;
    logic [DEPTH_W-1:0] waddr;
    logic cap_bank;
    logic host_bank;
    logic host_full;
    logic done;
    logic cont;
    mode_t mode;
    logic gain;
    logic mixed;
    logic [1:0] zoom;
    logic [DIVL_W-1:0] div_log;
    logic [DEPTH_W-1:0] depth;
    logic [TRIG_SRC_W-1:0] trig_src;
    logic [EXT_TRIG_N-1:0] trig_out;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [DEPTH_W-1:0] rd_addr;
    logic [EXT_TRIG_N-1:0] sy1;
    logic [EXT_TRIG_N-1:0] sy2;
    logic [EXT_TRIG_N-1:0] sy3;
    logic [EXT_TRIG_N-1:0] ext_lvl;
    logic trig_o;
    logic [31:0] rdata;
  } top_state_t;

  localparam top_state_t TOP_RST = '{
    st: ACQ_IDLE,
    mode: MODE_AVG,
    depth: DMAX,
    default: '0
  };

  top_state_t q_reg, q_next;

  rec_t rec_a, rec_b;
  red_cfg_t red_cfg;
  logic red_clr;
  logic cfg_wr;
  logic buf_we;
  logic [2*REC_W-1:0] buf_rd;
  logic [EXT_TRIG_N-1:0] ext_ev;
  logic [TRIG_SRC_W-1:0] src_ev;
  logic trig_hit;
  logic wr_ctrl;
  logic [31:0] wd;
  logic [DEPTH_W-1:0] new_depth;
  logic [31:0] rd_word;

  // reducer setup; a config write restarts the groups so entries never mix settings
  assign red_cfg = '{mode: q_reg.mode, div_log: q_reg.div_log, zoom: q_reg.zoom};
  assign cfg_wr = reg_req.wr && (reg_req.addr == REG_CTRL || reg_req.addr == REG_DIV);
  assign red_clr = (q_reg.st != ACQ_CAPT) || cfg_wr;

  // both channels share one config and clear, so their entries stay aligned
  sample_reducer u_red_a (
    .core_clk(core_clk),
    .rstn(rstn),
    .cfg(red_cfg),
    .clear(red_clr),
    .sample(adc_a),
    .rec(rec_a)
  ); // [RULE12]

  sample_reducer u_red_b (
    .core_clk(core_clk),
    .rstn(rstn),
    .cfg(red_cfg),
    .clear(red_clr),
    .sample(adc_b),
    .rec(rec_b)
  ); // [RULE12]

  // an entry is written on each reducer output while capturing
  assign buf_we = (q_reg.st == ACQ_CAPT) && rec_a.valid;

  capture_buffer #(
    .WIDTH(2 * REC_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .core_clk(core_clk),
    .we(buf_we),
    .wbank(q_reg.cap_bank),
    .waddr(q_reg.waddr[AW-1:0]),
    .wdata({rec_b.word, rec_a.word}),
    .rbank(q_reg.host_bank),
    .raddr(q_reg.rd_addr[AW-1:0]),
    .rdata(buf_rd)
  ); // [RULE7] [RULE8]

  // trigger sources; pins we drive ourselves are not read back
  always_comb begin
    ext_ev = ~(q_reg.sy2 ^ q_reg.sy3) & q_reg.sy3 & ~q_reg.ext_lvl & ~q_reg.trig_out;
    src_ev = {ext_ev, trig_inst}; // [RULE10]
    wr_ctrl = reg_req.wr && reg_req.addr == REG_CTRL;
    trig_hit = |(src_ev & q_reg.trig_src) || (q_reg.trig_src == '0) ||
               (wr_ctrl && reg_req.wdata[CTRL_FORCE]);
  end

  // depth writes are clamped to what this build holds
  always_comb begin
    wd = reg_req.wdata;
    new_depth = wd[DEPTH_W-1:0];
    if (new_depth == '0 || new_depth > DMAX) new_depth = DMAX; // [RULE8]
  end

  // register read mux
  always_comb begin
    case (reg_req.addr)
      REG_CTRL: rd_word = 32'(
        {q_reg.zoom, 1'b0, q_reg.mixed, q_reg.gain, q_reg.mode, q_reg.cont, 1'b0});
      REG_DIV: rd_word = 32'(q_reg.div_log);
      REG_DEPTH: rd_word = 32'(q_reg.depth);
      REG_TRIG: rd_word = 32'({q_reg.trig_out, q_reg.trig_src});
      REG_STATUS: rd_word = 32'({q_reg.host_bank, q_reg.host_full,
                                 q_reg.st != ACQ_IDLE, q_reg.done});
      REG_IRQ_STAT: rd_word = 32'(q_reg.irq_stat);
      REG_IRQ_MASK: rd_word = 32'(q_reg.irq_mask);
      REG_RD_ADDR: rd_word = 32'(q_reg.rd_addr);
      REG_RD_A: rd_word = 32'(buf_rd[REC_W-1:0]);
      REG_RD_B: rd_word = 32'(buf_rd[2*REC_W-1:REC_W]);
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // next state: registers, pin synchroniser, acquisition sequence
  always_comb begin
    q_next = q_reg;
    q_next.trig_o = 1'b0;
    q_next.rdata = reg_req.rd ? rd_word : 32'h0000_0000;

    // three-stage pin sync; a level counts once stages two and three agree
    q_next.sy1 = trig_pin_i;
    q_next.sy2 = q_reg.sy1;
    q_next.sy3 = q_reg.sy2;
    for (int i = 0; i < EXT_TRIG_N; i++) begin
      if (q_reg.sy2[i] == q_reg.sy3[i]) q_next.ext_lvl[i] = q_reg.sy3[i];
    end

    // software writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        REG_CTRL: begin
          q_next.cont = wd[CTRL_CONT];
          q_next.mode = mode_t'(wd[CTRL_MODE+:2]);
          q_next.gain = wd[CTRL_GAIN]; // [RULE11]
          q_next.mixed = wd[CTRL_MIXED];
          q_next.zoom = wd[CTRL_ZOOM+:2];
        end
        REG_DIV: q_next.div_log = wd[DIVL_W-1:0];
        REG_DEPTH: q_next.depth = new_depth;
        REG_TRIG: begin
          q_next.trig_src = wd[TRIG_SRC_W-1:0];
          q_next.trig_out = wd[TRIG_OUT+:EXT_TRIG_N];
        end
        REG_IRQ_MASK: q_next.irq_mask = wd[IRQ_W-1:0];
        REG_RD_ADDR: q_next.rd_addr = wd[DEPTH_W-1:0];
        REG_RELEASE: if (wd[0]) q_next.host_full = 1'b0;
        default: ;
      endcase
    end

    // reading the second channel steps the host read index
    if (reg_req.rd && reg_req.addr == REG_RD_B) q_next.rd_addr = q_reg.rd_addr + 1'b1;

    // write-one-to-clear; events below are applied later so set wins
    if (reg_req.wr && reg_req.addr == REG_IRQ_STAT) begin
      q_next.irq_stat = q_reg.irq_stat & ~wd[IRQ_W-1:0];
    end

    // acquisition sequence
    case (q_reg.st)
      ACQ_IDLE: begin
        if (wr_ctrl && wd[CTRL_RUN]) q_next.st = ACQ_ARMED;
      end
      ACQ_ARMED: begin
        if (trig_hit) begin
          q_next.st = ACQ_CAPT;
          q_next.waddr = '0;
          q_next.done = 1'b0; // [RULE14]
          q_next.trig_o = 1'b1; // [RULE10]
          q_next.irq_stat[IRQ_TRIG] = 1'b1;
        end
      end
      ACQ_CAPT: begin
        if (buf_we) begin
          q_next.waddr = q_reg.waddr + 1'b1;
          if (q_reg.waddr == q_reg.depth - 1'b1) q_next.st = ACQ_DONE;
        end
      end
      ACQ_DONE: begin
        // hand the full bank over and capture into the other one
        q_next.done = 1'b1; // [RULE14]
        q_next.host_bank = q_reg.cap_bank;
        q_next.cap_bank = ~q_reg.cap_bank;
        q_next.host_full = 1'b1;
        q_next.rd_addr = '0;
        q_next.irq_stat[IRQ_DONE] = 1'b1;
        // host still holding the old bank: its data is lost, say so
        if (q_reg.host_full) q_next.irq_stat[IRQ_OVR] = 1'b1;
        q_next.st = q_reg.cont ? ACQ_ARMED : ACQ_IDLE; // [RULE9]
      end
      default: q_next.st = ACQ_IDLE;
    endcase

    // stop wins over everything except the done hand-over
    if (wr_ctrl && wd[CTRL_STOP] && q_reg.st != ACQ_DONE) q_next.st = ACQ_IDLE;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) q_reg <= TOP_RST;
    else q_reg <= q_next;
  end

  // outputs, all from flip-flops apart from irq and the shared sample tick, which gate flip-flops
  assign reg_rdata = q_reg.rdata;
  assign gain_hi = q_reg.gain;
  assign trig_own = q_reg.trig_o;
  assign trig_pin_o = {EXT_TRIG_N{q_reg.trig_o}};
  assign trig_pin_oe_n = ~q_reg.trig_out;
  assign host_ready = q_reg.host_full;
  assign host_bank = q_reg.host_bank;
  assign irq = |(q_reg.irq_stat & q_reg.irq_mask);
  // digital lines store on the very tick the scope stores, one reference
  assign la_sample_tick = q_reg.mixed && buf_we; // [RULE6]

  // checking helpers: spacing between reducer entries
  logic [CNT_W:0] gap_reg;
  logic gap_ok_reg;
  logic [CNT_W:0] nlen;

  assign nlen = (CNT_W + 1)'(1) << q_reg.div_log;

  always_ff @(posedge core_clk) begin
    if (!rstn || red_clr) begin
      gap_reg <= '0;
      gap_ok_reg <= 1'b0;
    end else if (rec_a.valid) begin
      gap_reg <= (CNT_W + 1)'(1);
      gap_ok_reg <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_every_cycle: assert property ( // [RULE1]
    rec_a.valid && q_reg.div_log == '0 && q_reg.mode != MODE_MINMAX && !red_clr
    |=> rec_a.valid)
    else $error("an adc word was not taken in a cycle");

  a_group_len: assert property ( // [RULE2]
    rec_a.valid && gap_ok_reg && !red_clr && q_reg.mode != MODE_MINMAX
    |-> gap_reg == nlen)
    else $error("entry spacing differs from n");

  a_minmax_half: assert property ( // [RULE5]
    rec_a.valid && gap_ok_reg && !red_clr && q_reg.mode == MODE_MINMAX
    |-> gap_reg == (nlen << 1))
    else $error("min/max spacing is not 2n");

  a_chan_align: assert property ( // [RULE12]
    rec_a.valid == rec_b.valid)
    else $error("channels out of step");

  a_mixed_tick: assert property ( // [RULE6]
    q_reg.mixed && q_reg.st == ACQ_CAPT && rec_a.valid |-> la_sample_tick)
    else $error("mixed tick missing on a scope write");

  a_depth_range: assert property ( // [RULE8]
    q_reg.depth != '0 && q_reg.depth <= DMAX)
    else $error("depth outside the build limit");

  a_done_set: assert property ( // [RULE14]
    q_reg.st == ACQ_CAPT && buf_we && q_reg.waddr == q_reg.depth - 1'b1
    |=> ##1 q_reg.done && host_ready)
    else $error("done not raised after last entry");

  a_done_clear: assert property ( // [RULE14]
    q_reg.st == ACQ_CAPT |-> !q_reg.done)
    else $error("done still set while capturing");

  a_auto_restart: assert property ( // [RULE9]
    q_reg.st == ACQ_DONE && q_reg.cont && !wr_ctrl |=> q_reg.st == ACQ_ARMED)
    else $error("capture did not restart");

  a_trig_pulse: assert property ( // [RULE10]
    q_reg.st == ACQ_ARMED && trig_hit |=> trig_own ##1 !trig_own)
    else $error("own trigger not a one-cycle pulse");

  a_gain_write: assert property ( // [RULE11]
    wr_ctrl |=> gain_hi == $past(reg_req.wdata[CTRL_GAIN]))
    else $error("gain select not taken");

  c_minmax_entry: cover property (buf_we && q_reg.mode == MODE_MINMAX);
  c_bank_full: cover property (q_reg.st == ACQ_DONE ##1 q_reg.st == ACQ_ARMED);
  c_overrun: cover property ($rose(q_reg.irq_stat[IRQ_OVR]));
  c_pin_trig: cover property (|ext_ev && q_reg.st == ACQ_ARMED);
endmodule // scope_sample_rate_reducer

// ===== dv/adc_model.sv
// stand-in for the two-channel adc: a four-phase ramp on each channel
module adc_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // adc words, one per channel each cycle
  output logic [13:0] adc_a,
  output logic [13:0] adc_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_reg;
  // a new word on every rising edge; a period of four keeps group means and min/max free of phase
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  // channel b mirrors a negatively, so signed handling shows up
  assign adc_a = {10'h000, phase_reg, 2'h0};
  assign adc_b = 14'h0000 - adc_a;
endmodule // adc_model

// ===== dv/scope_sample_rate_reducer_test.sv
// self-checking bench of the scope sample rate reducer
module scope_sample_rate_reducer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import scope_pkg::*;
  localparam int DEPTH = 4;
  logic core_clk, rstn;
  logic [13:0] adc_a, adc_b;
  bus_req_t reg_req;
  logic [31:0] reg_rdata;
  logic [2:0] trig_inst;
  logic [1:0] trig_pin_i, trig_pin_o, trig_pin_oe_n;
  logic trig_own, gain_hi, la_sample_tick, host_ready, host_bank, irq;
  int fail_count, comparisons;
  logic [31:0] ea [DEPTH];
  logic [31:0] eb [DEPTH];

  scope_sample_rate_reducer #(.BUF_DEPTH(DEPTH)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .adc_a(adc_a), .adc_b(adc_b),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .trig_inst(trig_inst), .trig_own(trig_own),
    .trig_pin_i(trig_pin_i), .trig_pin_o(trig_pin_o), .trig_pin_oe_n(trig_pin_oe_n),
    .gain_hi(gain_hi), .la_sample_tick(la_sample_tick), .host_ready(host_ready),
    .host_bank(host_bank), .irq(irq)
  );
  adc_model adc_u (.core_clk(core_clk), .rstn(rstn), .adc_a(adc_a), .adc_b(adc_b));

  // 25 MHz sampling clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // register port cycles: one-cycle strobes, read data in the following cycle only
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // bounded wait for the own trigger pulse or for a full bank
  task automatic wait_for(input bit ready, input int lim, output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      #1 k++;
    end while ((ready ? host_ready : trig_own) !== 1'b1 && k < lim);
    chk({31'h0, ready ? host_ready : trig_own}, 32'h1);
  endtask

  // one triggered capture; cycles and mixed-signal ticks counted from the trigger
  task automatic capture(input logic [31:0] ctrl, input logic [3:0] dl, output int cyc,
                         output int ticks);
    int k;
    wr(REG_DIV, {28'h000_0000, dl});
    wr(REG_CTRL, ctrl | 32'h0000_0001);
    wait_for(1'b0, 16, k);
    cyc = 0;
    ticks = (la_sample_tick === 1'b1) ? 1 : 0;
    do begin
      @(posedge core_clk);
      #1 cyc++;
      ticks += (la_sample_tick === 1'b1) ? 1 : 0;
    end while (host_ready !== 1'b1 && cyc < 1000);
    chk({31'h0, host_ready}, 32'h0000_0001);
    wr(REG_RD_ADDR, 32'h0000_0000);
    for (int i = 0; i < DEPTH; i++) begin
      rd(REG_RD_A, ea[i]);
      rd(REG_RD_B, eb[i]);
    end
    wr(REG_RELEASE, 32'h0000_0001);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    chk({30'h0, trig_pin_oe_n}, 32'h0000_0003);
    rd(REG_CTRL, d);
    chk(d, 32'h0000_0000);
    rd(REG_DEPTH, d);
    chk(d, 32'(DEPTH));
    rd(8'h3c, d);
    chk(d, 32'h0000_0000);
  endtask

  task automatic t_avg();
    int cyc, ticks;
    capture(32'h0000_0030, 4'h2, cyc, ticks);
    chk({31'h0, gain_hi}, 32'h0000_0001);
    chk(32'(cyc), 32'(4 * DEPTH + 2));
    chk(32'(ticks), 32'(DEPTH));
    for (int i = 0; i < DEPTH; i++) begin
      chk(ea[i], 32'h0000_0006);
      chk(eb[i], 32'h0000_3ffa);
    end
  endtask

  task automatic t_pass();
    int cyc, ticks;
    logic [31:0] d;
    capture(32'h0000_0000, 4'h0, cyc, ticks);
    chk({31'h0, gain_hi}, 32'h0000_0000);
    chk(32'(ticks), 32'h0000_0000);
    for (int i = 0; i < DEPTH - 1; i++) begin
      chk((ea[i + 1] - ea[i]) & 32'h0000_000f, 32'h0000_0004);
    end
    // a shorter depth, then zero falls back to the build depth
    wr(REG_DEPTH, 32'h0000_0002);
    capture(32'h0000_0000, 4'h0, cyc, ticks);
    chk(32'(cyc), 32'h0000_0004);
    wr(REG_DEPTH, 32'h0000_0000);
    rd(REG_DEPTH, d);
    chk(d, 32'(DEPTH));
  endtask

  task automatic t_dec();
    int cyc, ticks;
    // zoom of one doubles each kept word, so channel a holds 0, 8, 16 or 24
    capture(32'h0000_0084, 4'h2, cyc, ticks);
    chk(ea[0] & 32'hffff_ffe7, 32'h0000_0000);
    for (int i = 0; i < DEPTH; i++) begin
      chk(ea[i], ea[0]);
      chk(eb[i], (32'h0000_0000 - ea[0]) & 32'h0000_3fff);
    end
  endtask

  task automatic t_mm();
    int cyc, ticks;
    capture(32'h0000_0008, 4'h1, cyc, ticks);
    chk(32'(cyc), 32'(4 * DEPTH + 2));
    for (int i = 0; i < DEPTH; i++) begin
      chk(ea[i], 32'h0003_0000);
      chk(eb[i], 32'h0000_3ff4);
    end
  endtask

  // done status is set by now but masked; unmask, then clear by writing ones
  task automatic t_irq();
    logic [31:0] d;
    rd(REG_IRQ_STAT, d);
    chk(d & 32'h0000_0001, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(REG_IRQ_MASK, 32'h0000_0001);
    @(posedge core_clk);
    #1 chk({31'h0, irq}, 32'h0000_0001);
    wr(REG_IRQ_STAT, 32'h0000_0007);
    @(posedge core_clk);
    #1 chk({31'h0, irq}, 32'h0000_0000);
    rd(REG_IRQ_STAT, d);
    chk(d, 32'h0000_0000);
  endtask

  // continuous capture never waits for the host; a second full bank overruns
  task automatic t_cont();
    int k;
    logic [31:0] d;
    logic b0;
    wr(REG_DIV, 32'h0000_0002);
    wr(REG_CTRL, 32'h0000_0003);
    wait_for(1'b1, 200, k);
    b0 = host_bank;
    wait_for(1'b0, 8, k);
    chk({31'h0, host_ready}, 32'h0000_0001);
    rd(REG_STATUS, d);
    chk(d & 32'h0000_0005, 32'h0000_0004);
    k = 0;
    do begin
      rd(REG_IRQ_STAT, d);
      k++;
    end while (d[2] !== 1'b1 && k < 30);
    chk(d & 32'h0000_0004, 32'h0000_0004);
    // the second full bank is the other one
    chk({31'h0, host_bank}, {31'h0, ~b0});
    wr(REG_CTRL, 32'h0000_0200);
    wr(REG_CTRL, 32'h0000_0200);
    wr(REG_RELEASE, 32'h0000_0001);
    wr(REG_RELEASE, 32'h0000_0001);
    wr(REG_IRQ_STAT, 32'h0000_0007);
  endtask

  // every trigger source in turn, then our own trigger driven onto both pins
  task automatic t_trig();
    int k;
    logic seen;
    for (int i = 0; i < 5; i++) begin
      wr(REG_TRIG, 32'h0000_0001 << i);
      wr(REG_CTRL, 32'h0000_0001);
      seen = 1'b0;
      repeat (6) begin
        @(posedge core_clk);
        #1 seen |= trig_own;
      end
      chk({31'h0, seen}, 32'h0000_0000);
      @(posedge core_clk);
      {trig_pin_i, trig_inst} <= 5'h01 << i;
      wait_for(1'b0, 12, k);
      @(posedge core_clk);
      {trig_pin_i, trig_inst} <= 5'h00;
      wait_for(1'b1, 200, k);
      wr(REG_RELEASE, 32'h0000_0001);
    end
    // a quiet source stays armed until software forces the trigger
    wr(REG_TRIG, 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_0040);
    #1 chk({31'h0, trig_own}, 32'h0000_0001);
    wait_for(1'b1, 200, k);
    wr(REG_RELEASE, 32'h0000_0001);
    wr(REG_TRIG, 32'h0000_0060);
    @(posedge core_clk);
    #1 chk({30'h0, trig_pin_oe_n}, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0001);
    wait_for(1'b0, 16, k);
    chk({30'h0, trig_pin_o}, 32'h0000_0003);
    wait_for(1'b1, 200, k);
    wr(REG_RELEASE, 32'h0000_0001);
    wr(REG_TRIG, 32'h0000_0000);
  endtask

  // a hang is cut short at 20000 cycles, well beyond the several hundred cycles the run needs
  initial begin
    #(20000 * 40);
    fail_count++;
    summarize();
  end

  initial begin
    rstn = 1'b0;
    reg_req = '0;
    trig_inst = 3'h0;
    trig_pin_i = 2'h0;
    fail_count = 0;
    comparisons = 0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_avg();
    t_pass();
    t_dec();
    t_mm();
    t_irq();
    t_cont();
    t_trig();
    summarize();
  end
endmodule // scope_sample_rate_reducer_test
